// File: att_cmd_pkg.sv
package att_cmd_pkg;

    // Register offsets on the command port
    localparam logic [7:0] OFF_SLOT_FIRST = 8'h02;
    localparam logic [7:0] OFF_SLOT_LAST  = 8'h08;
    localparam logic [7:0] OFF_RDBACK_HI  = 8'h0a;
    localparam logic [7:0] OFF_RDBACK_LO  = 8'h0c;
    localparam logic [7:0] OFF_STATUS     = 8'h0e;
    localparam logic [7:0] OFF_CMD        = 8'h10;
    localparam logic [7:0] OFF_ADDR       = 8'h12;

    // Reset values and limits
    localparam logic [6:0]  DEFAULT_TARGET = 7'h49;
    localparam logic [15:0] CMD_RESET      = 16'h0000;
    localparam logic [3:0]  MAX_BYTES      = 4'h8;

    // Field positions in status and address registers
    localparam int ST_BUSY     = 0;
    localparam int ST_PENDING  = 1;
    localparam int ST_NACK     = 2;
    localparam int ADDR_OWN    = 8;

    // Two-wire timing: quarter of a 100 kHz bit, rounded up to whole cycles
    localparam int CLK_FREQ_MHZ  = 25;
    localparam int QTR_PERIOD_NS = 2500;
    localparam int QTR_CYCLES    = (QTR_PERIOD_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam logic [5:0] QTR_LAST = 6'(QTR_CYCLES - 1);

    // Sizes
    localparam int SLOTS      = 4;
    localparam int RX_BYTES   = 4;
    localparam int FIFO_DEPTH = 8;

    // Command word layout
    typedef struct packed {
        logic [3:0] rdCount;
        logic [3:0] wrCount;
        logic [7:0] code;
    } cmd_word_t;

    // One queued transaction
    typedef struct packed {
        logic [1:0]  slot;
        logic [6:0]  target;
        cmd_word_t   cmd;
        logic [15:0] data;
    } txn_t;

    typedef enum logic [2:0] {S_IDLE, S_START, S_WRITE, S_READ, S_STOP} engine_state_t;

endpackage

// File: txn_fifo.sv
`timescale 1ns/1ps
module txn_fifo #(
    parameter int WIDTH = 41,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // Filling side
    input  wire logic             inValid,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  inReady,
    // Draining side
    output logic                  outValid,
    output logic [WIDTH-1:0]      outData,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
    logic [AW:0]      count_q, count_d;
    logic             ready_q, ready_d;
    logic             doPush, doPop;

    // Pointer and level bookkeeping
    always_comb
    begin
        doPush  = inValid && ready_q;
        doPop   = outReady && (count_q != '0);
        wrPtr_d = doPush ? wrPtr_q + 1'b1 : wrPtr_q;
        rdPtr_d = doPop ? rdPtr_q + 1'b1 : rdPtr_q;
        count_d = count_q + (AW+1)'(doPush) - (AW+1)'(doPop);
        ready_d = (count_d != (AW+1)'(DEPTH));
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
            ready_q <= 1'b1;
        end
        else
        begin
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
            count_q <= count_d;
            ready_q <= ready_d;
        end
    end

    // Storage, no reset needed
    always_ff @(posedge clk)
    begin
        if (doPush)
            mem[wrPtr_q] <= inData;
    end

    assign inReady  = ready_q;
    assign outValid = (count_q != '0);
    assign outData  = mem[rdPtr_q];

endmodule // txn_fifo

// File: attenuator_i2c_command_port.sv
`timescale 1ns/1ps
module attenuator_i2c_command_port (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Register port
    input  wire logic [7:0]  regAddr,
    input  wire logic        regWr,
    input  wire logic        regRd,
    input  wire logic [15:0] regWrData,
    output logic      [15:0] regRdData,
    output logic             portReady,
    // Per-slot two-wire pins, enable high pulls low
    input  wire logic [3:0]  sclIn,
    output logic      [3:0]  sclOut,
    output logic      [3:0]  sclOe,
    input  wire logic [3:0]  sdaIn,
    output logic      [3:0]  sdaOut,
    output logic      [3:0]  sdaOe
);
    localparam int TW = $bits(att_cmd_pkg::txn_t);

    att_cmd_pkg::cmd_word_t     cmdWord_q, cmdWord_d;
    att_cmd_pkg::txn_t          job_q, job_d, pushData, fifoData;
    att_cmd_pkg::engine_state_t state_q, state_d;
    logic [6:0]  target_q, target_d;
    logic        useOwn_q, useOwn_d, nack_q, nack_d, nackSet;
    logic [15:0] rdData_q, rdData_d;
    logic [7:0]  rx_q [att_cmd_pkg::RX_BYTES];
    logic [7:0]  rx_d [att_cmd_pkg::RX_BYTES];
    logic [7:0]  shift_q, shift_d;
    logic [5:0]  divCnt_q, divCnt_d;
    logic [1:0]  phase_q, phase_d;
    logic [3:0]  bitCnt_q, bitCnt_d, wLeft_q, wLeft_d, rLeft_q, rLeft_d;
    logic [2:0]  byteIdx_q, byteIdx_d, rxIdx_q, rxIdx_d;
    logic        rdHdr_q, rdHdr_d, lastAck_q, lastAck_d;
    logic [3:0]  sclOe_q, sclOe_d, sdaOe_q, sdaOe_d, lineZero_q;
    logic [3:0]  sclMeta_q, sclSync_q, sdaMeta_q, sdaSync_q;
    logic        isSlot, pushValid, fifoValid, pop, tickNow, adv, sclSel, sdaSel, sclLow, sdaLow;
    logic [3:0]  wCap, rCap;

    // Two-flop synchronisers, one per slot and line
    for (genvar i = 0; i < att_cmd_pkg::SLOTS; i++)
    begin : g_sync
        always_ff @(posedge clk or negedge reset_n)
        begin
            if (!reset_n)
            begin
                sclMeta_q[i] <= 1'b1;
                sclSync_q[i] <= 1'b1;
                sdaMeta_q[i] <= 1'b1;
                sdaSync_q[i] <= 1'b1;
            end
            else
            begin
                sclMeta_q[i] <= sclIn[i];
                sclSync_q[i] <= sclMeta_q[i];
                sdaMeta_q[i] <= sdaIn[i];
                sdaSync_q[i] <= sdaMeta_q[i];
            end
        end
    end

    // Slot decode and queue entry
    always_comb
    begin
        isSlot    = !regAddr[0] && regAddr >= att_cmd_pkg::OFF_SLOT_FIRST
                    && regAddr <= att_cmd_pkg::OFF_SLOT_LAST;
        pushValid = regWr && isSlot;
        pushData.slot   = 2'(regAddr[3:1] - 3'h1);
        pushData.target = useOwn_q ? target_q : att_cmd_pkg::DEFAULT_TARGET;
        pushData.cmd    = cmdWord_q;
        pushData.data   = regWrData;
    end

    txn_fifo #(.WIDTH(TW), .DEPTH(att_cmd_pkg::FIFO_DEPTH)) u_fifo (
        .clk      (clk),
        .reset_n  (reset_n),
        .inValid  (pushValid),
        .inData   (pushData),
        .inReady  (portReady),
        .outValid (fifoValid),
        .outData  (fifoData),
        .outReady (pop)
    );

    // Software registers and read mux
    always_comb
    begin
        cmdWord_d = cmdWord_q;
        target_d  = target_q;
        useOwn_d  = useOwn_q;
        rdData_d  = rdData_q;
        nack_d    = nackSet || (nack_q && !(regWr && regAddr == att_cmd_pkg::OFF_STATUS
                    && regWrData[att_cmd_pkg::ST_NACK]));
        if (regWr && regAddr == att_cmd_pkg::OFF_CMD)
            cmdWord_d = regWrData;
        if (regWr && regAddr == att_cmd_pkg::OFF_ADDR)
        begin
            target_d = regWrData[6:0];
            useOwn_d = regWrData[att_cmd_pkg::ADDR_OWN];
        end
        if (regRd)
        begin
            unique case (regAddr)
                att_cmd_pkg::OFF_RDBACK_HI: rdData_d = {rx_q[0], rx_q[1]};
                att_cmd_pkg::OFF_RDBACK_LO: rdData_d = {rx_q[2], rx_q[3]};
                att_cmd_pkg::OFF_STATUS:    rdData_d = {13'h0000, nack_q, fifoValid, state_q != att_cmd_pkg::S_IDLE};
                att_cmd_pkg::OFF_CMD:       rdData_d = cmdWord_q;
                att_cmd_pkg::OFF_ADDR:      rdData_d = {7'h00, useOwn_q, 1'b0, target_q};
                default:                    rdData_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cmdWord_q <= att_cmd_pkg::CMD_RESET;
            target_q  <= att_cmd_pkg::DEFAULT_TARGET;
            useOwn_q  <= 1'b0;
            rdData_q  <= 16'h0000;
            nack_q    <= 1'b0;
        end
        else
        begin
            cmdWord_q <= cmdWord_d;
            target_q  <= target_d;
            useOwn_q  <= useOwn_d;
            rdData_q  <= rdData_d;
            nack_q    <= nack_d;
        end
    end

    // Byte sent at a given position of the write phase
    function automatic logic [7:0] writeByte(input logic [2:0] idx, input att_cmd_pkg::txn_t j);
        unique case (idx)
            3'h1:    writeByte = j.cmd.code;
            3'h2:    writeByte = j.data[15:8];
            3'h3:    writeByte = j.data[7:0];
            default: writeByte = 8'h00;
        endcase
    endfunction

    // Quarter-bit divider and transfer engine
    always_comb
    begin
        state_d = state_q;  phase_d = phase_q;  bitCnt_d = bitCnt_q;  byteIdx_d = byteIdx_q;
        wLeft_d = wLeft_q;  rLeft_d = rLeft_q;  shift_d = shift_q;    job_d = job_q;
        rdHdr_d = rdHdr_q;  rxIdx_d = rxIdx_q;  lastAck_d = lastAck_q;
        rx_d    = rx_q;
        nackSet = 1'b0;
        pop     = 1'b0;
        sclSel  = sclSync_q[job_q.slot];
        sdaSel  = sdaSync_q[job_q.slot];
        tickNow = (divCnt_q == att_cmd_pkg::QTR_LAST);
        divCnt_d = (state_q == att_cmd_pkg::S_IDLE || tickNow) ? 6'h00 : divCnt_q + 6'h01;
        adv     = tickNow && !(phase_q == 2'h2 && !sclSel); // wait out clock stretching
        wCap    = (fifoData.cmd.wrCount > att_cmd_pkg::MAX_BYTES) ? att_cmd_pkg::MAX_BYTES
                  : fifoData.cmd.wrCount;
        rCap    = (fifoData.cmd.rdCount > att_cmd_pkg::MAX_BYTES) ? att_cmd_pkg::MAX_BYTES
                  : fifoData.cmd.rdCount;
        if (adv)
            phase_d = phase_q + 2'h1;
        unique case (state_q)
            att_cmd_pkg::S_IDLE:
                if (fifoValid)
                begin
                    pop       = 1'b1;
                    job_d     = fifoData;
                    wLeft_d   = wCap;
                    rLeft_d   = (rCap >= 4'h2) ? rCap - 4'h1 : 4'h0;
                    rdHdr_d   = (wCap == 4'h0);
                    byteIdx_d = 3'h0;
                    rxIdx_d   = 3'h0;
                    phase_d   = 2'h0;
                    if (wCap != 4'h0 || rCap >= 4'h2)
                    begin
                        state_d = att_cmd_pkg::S_START;
                        for (int k = 0; k < att_cmd_pkg::RX_BYTES; k++)
                            rx_d[k] = 8'h00;
                    end
                end
            att_cmd_pkg::S_START:
                if (adv && phase_q == 2'h3)
                begin
                    state_d  = att_cmd_pkg::S_WRITE;
                    bitCnt_d = 4'h0;
                    shift_d  = {job_q.target, rdHdr_q};
                end
            att_cmd_pkg::S_WRITE:
                if (adv && phase_q == 2'h2 && bitCnt_q == 4'h8)
                    lastAck_d = sdaSel;
                else if (adv && phase_q == 2'h3)
                begin
                    bitCnt_d = bitCnt_q + 4'h1;
                    shift_d  = {shift_q[6:0], 1'b0};
                    if (bitCnt_q == 4'h8)
                    begin
                        bitCnt_d = 4'h0;
                        if (lastAck_q)
                        begin
                            nackSet = 1'b1;
                            state_d = att_cmd_pkg::S_STOP;
                        end
                        else if (rdHdr_q)
                            state_d = att_cmd_pkg::S_READ;
                        else
                        begin
                            wLeft_d   = wLeft_q - 4'h1;
                            byteIdx_d = byteIdx_q + 3'h1;
                            shift_d   = writeByte(byteIdx_q + 3'h1, job_q);
                            if (wLeft_q == 4'h1)
                            begin
                                rdHdr_d = 1'b1;
                                state_d = (rLeft_q != 4'h0) ? att_cmd_pkg::S_START : att_cmd_pkg::S_STOP;
                            end
                        end
                    end
                end
            att_cmd_pkg::S_READ:
                if (adv && phase_q == 2'h2 && bitCnt_q != 4'h8)
                    shift_d = {shift_q[6:0], sdaSel};
                else if (adv && phase_q == 2'h3)
                begin
                    bitCnt_d = bitCnt_q + 4'h1;
                    if (bitCnt_q == 4'h8)
                    begin
                        bitCnt_d = 4'h0;
                        if (rxIdx_q < 3'(att_cmd_pkg::RX_BYTES))
                            rx_d[rxIdx_q[1:0]] = shift_q;
                        rxIdx_d = rxIdx_q + 3'h1;
                        rLeft_d = rLeft_q - 4'h1;
                        if (rLeft_q == 4'h1)
                            state_d = att_cmd_pkg::S_STOP;
                    end
                end
            att_cmd_pkg::S_STOP:
                if (adv && phase_q == 2'h3)
                    state_d = att_cmd_pkg::S_IDLE;
            default:
                state_d = att_cmd_pkg::S_IDLE;
        endcase
        // Line levels for the active slot only
        unique case (state_q)
            att_cmd_pkg::S_START: begin sclLow = phase_q == 2'h3 || (phase_q == 2'h0 && rdHdr_q);
                                        sdaLow = phase_q[1]; end
            att_cmd_pkg::S_WRITE: begin sclLow = phase_q == 2'h0 || phase_q == 2'h3;
                                        sdaLow = bitCnt_q != 4'h8 && !shift_q[7]; end
            att_cmd_pkg::S_READ:  begin sclLow = phase_q == 2'h0 || phase_q == 2'h3;
                                        sdaLow = bitCnt_q == 4'h8 && rLeft_q > 4'h1; end
            att_cmd_pkg::S_STOP:  begin sclLow = phase_q == 2'h0;
                                        sdaLow = !phase_q[1]; end
            default:              begin sclLow = 1'b0;
                                        sdaLow = 1'b0; end
        endcase
        sclOe_d = {3'b000, sclLow} << job_q.slot;
        sdaOe_d = {3'b000, sdaLow} << job_q.slot;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= att_cmd_pkg::S_IDLE;  phase_q <= 2'h0;  bitCnt_q <= 4'h0;  byteIdx_q <= 3'h0;
            wLeft_q <= 4'h0;  rLeft_q <= 4'h0;  shift_q <= 8'h00;  job_q <= '0;
            rdHdr_q <= 1'b0;  rxIdx_q <= 3'h0;  lastAck_q <= 1'b0;  divCnt_q <= 6'h00;
            sclOe_q <= 4'h0;  sdaOe_q <= 4'h0;  lineZero_q <= 4'h0;
            for (int k = 0; k < att_cmd_pkg::RX_BYTES; k++)
                rx_q[k] <= 8'h00;
        end
        else
        begin
            state_q <= state_d;  phase_q <= phase_d;  bitCnt_q <= bitCnt_d;  byteIdx_q <= byteIdx_d;
            wLeft_q <= wLeft_d;  rLeft_q <= rLeft_d;  shift_q <= shift_d;  job_q <= job_d;
            rdHdr_q <= rdHdr_d;  rxIdx_q <= rxIdx_d;  lastAck_q <= lastAck_d;  divCnt_q <= divCnt_d;
            sclOe_q <= sclOe_d;  sdaOe_q <= sdaOe_d;  lineZero_q <= 4'h0;
            rx_q    <= rx_d;
        end
    end

    assign regRdData = rdData_q;
    assign sclOe     = sclOe_q;
    assign sdaOe     = sdaOe_q;
    assign sclOut    = lineZero_q;
    assign sdaOut    = lineZero_q;

    // Checks
    a_slot_isolation: assert property (@(posedge clk) disable iff (!reset_n)
        ((sclOe_q | sdaOe_q) & ~({3'b000, 1'b1} << $past(job_q.slot))) == 4'h0)
        else $error("Pins of an inactive slot driven");
    a_default_target: assert property (@(posedge clk) disable iff (!reset_n)
        pushValid && !useOwn_q |-> pushData.target == 7'h49)
        else $error("Default target not used");
    a_port_starts: assert property (@(posedge clk) disable iff (!reset_n)
        pushValid && portReady && !fifoValid && state_q == att_cmd_pkg::S_IDLE
        && (cmdWord_q.wrCount != 4'h0) |-> ##[1:3] state_q == att_cmd_pkg::S_START)
        else $error("Data port write did not start transfer");
    a_cmd_after_addr: assert property (@(posedge clk) disable iff (!reset_n)
        state_q == att_cmd_pkg::S_WRITE && byteIdx_q == 3'h1 && bitCnt_q == 4'h0 && !rdHdr_q
        |-> shift_q == job_q.cmd.code)
        else $error("Command byte not second");
    a_rdback_clear: assert property (@(posedge clk) disable iff (!reset_n)
        state_q == att_cmd_pkg::S_IDLE && state_d == att_cmd_pkg::S_START |=> rx_q[0] == 8'h00 && rx_q[3] == 8'h00)
        else $error("Read-back not overwritten");
    a_read_count: assert property (@(posedge clk) disable iff (!reset_n)
        state_q == att_cmd_pkg::S_READ |-> rLeft_q != 4'h0 && rLeft_q < 4'h8)
        else $error("Read count out of range");
    a_write_count: assert property (@(posedge clk) disable iff (!reset_n)
        state_q == att_cmd_pkg::S_WRITE && !rdHdr_q |-> wLeft_q != 4'h0 && wLeft_q <= 4'h8)
        else $error("Write count out of range");
    a_cmd_layout: assert property (@(posedge clk) disable iff (!reset_n)
        regWr && regAddr == att_cmd_pkg::OFF_CMD |=> cmdWord_q.rdCount == $past(regWrData[15:12])
        && cmdWord_q.wrCount == $past(regWrData[11:8]))
        else $error("Command word fields misplaced");
    a_read_header: assert property (@(posedge clk) disable iff (!reset_n)
        state_q == att_cmd_pkg::S_WRITE ##1 state_q == att_cmd_pkg::S_READ |-> rdHdr_q && rLeft_q != 4'h0)
        else $error("Read phase without read header");
    c_write_job: cover property (@(posedge clk) state_q == att_cmd_pkg::S_WRITE ##1 state_q == att_cmd_pkg::S_STOP);
    c_read_job: cover property (@(posedge clk) state_q == att_cmd_pkg::S_READ ##1 state_q == att_cmd_pkg::S_STOP);
    c_nack: cover property (@(posedge clk) nackSet);
    c_queue_full: cover property (@(posedge clk) !portReady);

endmodule // attenuator_i2c_command_port

// File: att_module_model.sv
`timescale 1ns/1ps
module att_module_model #(
    parameter logic [6:0]  ADDR  = 7'h49,
    parameter logic [31:0] REPLY = 32'h0b1d_5a63
) (
    // Resolved wire levels
    input  wire logic   scl,
    input  wire logic   sda,
    // Pull-down on the data line
    output logic        sdaOe,
    // What the last command carried, and a running count of acknowledged written bytes
    output logic [7:0]  lastCode,
    output logic [15:0] lastData,
    output int          wrTotal
);
    logic [7:0] sh;
    logic       rd;
    logic       act;
    int         cnt;
    int         nb;
    int         rb;
    initial
    begin
        sdaOe = 1'b0;
        act = 1'b0;
        wrTotal = 0;
    end
    // Start or repeated start opens a frame, stop closes it
    always @(negedge sda) if (scl === 1'b1) {act, rd, cnt, nb, rb} = {2'b10, 32'd0, 32'd0, -32'sd1};
    always @(posedge sda) if (scl === 1'b1) act = 1'b0;
    // Shift in bits; a master nack ends the reply
    always @(posedge scl) if (act)
    begin
        if (cnt < 8) {sh, cnt} = {sh[6:0], sda, cnt + 1};
        else
        begin
            cnt = 0;
            if (rd) rb = rb + 1;
            if (rd && sda) act = 1'b0;
        end
        if (cnt == 8 && !(rd && nb > 0))
        begin
            if (nb == 0) {rd, act} = {sh[0], sh[7:1] == ADDR};
            else if (nb == 1) lastCode = sh;
            else if (nb == 2) lastData[15:8] = sh;
            else if (nb == 3) lastData[7:0] = sh;
            if (act && !rd) wrTotal = wrTotal + 1;
            nb = nb + 1;
        end
    end
    // Acknowledge written bytes, send reply upper octet first, release otherwise
    always @(negedge scl) if (act)
    begin
        #100;
        if (cnt == 8) sdaOe = (rb < 0) || !rd;
        else if (rd && rb >= 0 && rb < 4) sdaOe = ~REPLY[31 - 8 * rb - cnt];
        else sdaOe = 1'b0;
    end
endmodule // att_module_model

// File: attenuator_i2c_command_port_test.sv
`timescale 1ns/1ps
module attenuator_i2c_command_port_test;
    typedef struct packed {logic [1:0] slot; logic [15:0] cmd; logic [15:0] data;} row_t;
    localparam logic [31:0] REPLY = 32'h0b1d_5a63;
    logic        clk;
    logic        reset_n;
    logic [7:0]  regAddr;
    logic        regWr;
    logic        regRd;
    logic [15:0] regWrData;
    logic [15:0] regRdData;
    logic        portReady;
    logic [3:0]  sclIn, sclOe, sdaIn, sdaOe, slvOe;
    logic [7:0]  lastCode [4];
    logic [15:0] lastData [4];
    int          wrTotal [4];
    int          wrBase [4];
    int          errCount;
    int          checks;
    logic [15:0] got;
    logic [31:0] exp32;
    row_t        rows [5];
    // Open-drain wires with pull-ups
    assign sclIn = ~sclOe;
    assign sdaIn = ~(sdaOe | slvOe);
    attenuator_i2c_command_port i_attenuator_i2c_command_port (.clk(clk), .reset_n(reset_n), .regAddr(regAddr),
        .regWr(regWr), .regRd(regRd), .regWrData(regWrData), .regRdData(regRdData), .portReady(portReady),
        .sclIn(sclIn), .sclOut(), .sclOe(sclOe), .sdaIn(sdaIn), .sdaOut(), .sdaOe(sdaOe));
    // One module per slot; slot 3 answers a non-default address
    for (genvar g = 0; g < 4; g++)
    begin : gen_mod
        att_module_model #(.ADDR(g == 3 ? 7'h21 : 7'h49), .REPLY(REPLY)) i_att_module_model (.scl(sclIn[g]),
            .sda(sdaIn[g]), .sdaOe(slvOe[g]), .lastCode(lastCode[g]), .lastData(lastData[g]), .wrTotal(wrTotal[g]));
    end
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] val);
        checks++;
        if (val !== exp)
        begin
            errCount++;
            $display("mismatch %s expected %h seen %h", name, exp, val);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        @(posedge clk);
        #1 got = regRdData;
    endtask
    // Poll status until neither busy nor queued
    task automatic idle();
        for (int n = 0; n < 20000; n++)
        begin
            rd(att_cmd_pkg::OFF_STATUS);
            if (got[1:0] === 2'b00) break;
        end
        chk("idle", 16'h0, {14'h0, got[1:0]});
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, errCount);
        if (errCount == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Watchdog: the tests need roughly 83,000 cycles of bus traffic
    initial
    begin
        repeat (95000) @(posedge clk);
        errCount++;
        end_of_test();
    end
    initial
    begin
        {reset_n, regAddr, regWr, regRd, regWrData, errCount, checks} = '0;
        rows = '{'{2'd0, 16'h0430, 16'h0b1d}, '{2'd1, 16'h3231, 16'h0}, '{2'd2, 16'h0480, 16'h0d6f},
                 '{2'd1, 16'h0390, 16'h4900}, '{2'd0, 16'h428b, 16'h0}};
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        // Reset state
        chk("rddata", 16'h0, regRdData);
        chk("ready", 16'h1, {15'h0, portReady});
        chk("oe", 16'h0, {8'h0, sclOe, sdaOe});
        rd(att_cmd_pkg::OFF_CMD);
        chk("cmd reset", 16'h0, got);
        rd(att_cmd_pkg::OFF_ADDR);
        chk("addr reset", 16'h0049, got);
        $display("test reset done");
        // Ordinary transactions
        foreach (rows[i])
        begin
            foreach (wrBase[m]) wrBase[m] = wrTotal[m];
            wr(att_cmd_pkg::OFF_CMD, rows[i].cmd);
            wr(att_cmd_pkg::OFF_SLOT_FIRST + {5'h0, rows[i].slot, 1'b0}, rows[i].data);
            idle();
            for (int m = 0; m < 4; m++)
                chk("bytes", m == rows[i].slot ? {12'h0, rows[i].cmd[11:8]} : 16'h0, 16'(wrTotal[m] - wrBase[m]));
            chk("code", {8'h0, rows[i].cmd[7:0]}, {8'h0, lastCode[rows[i].slot]});
            if (rows[i].cmd[11:8] >= 3) chk("data hi", {8'h0, rows[i].data[15:8]}, {8'h0, lastData[rows[i].slot][15:8]});
            if (rows[i].cmd[11:8] >= 4) chk("data", rows[i].data, lastData[rows[i].slot]);
            if (rows[i].cmd[15:12] >= 2)
            begin
                for (int k = 0; k < 4; k++)
                    exp32[31 - 8 * k -: 8] = (k < rows[i].cmd[15:12] - 1) ? REPLY[31 - 8 * k -: 8] : 8'h00;
                rd(att_cmd_pkg::OFF_RDBACK_HI);
                chk("rdback hi", exp32[31:16], got);
                rd(att_cmd_pkg::OFF_RDBACK_LO);
                chk("rdback lo", exp32[15:0], got);
            end
            $display("test row %0d done", i);
        end
        // Default address refused by slot 3; fill the queue until it refuses
        foreach (wrBase[m]) wrBase[m] = wrTotal[m];
        wr(att_cmd_pkg::OFF_CMD, 16'h0232);
        repeat (9) wr(att_cmd_pkg::OFF_SLOT_LAST, 16'h0);
        #1 chk("full", 16'h0, {15'h0, portReady});
        wr(att_cmd_pkg::OFF_SLOT_FIRST, 16'h0);
        idle();
        chk("dropped", 16'h0, 16'(wrTotal[0] - wrBase[0]));
        rd(att_cmd_pkg::OFF_RDBACK_HI);
        chk("rdback cleared", 16'h0, got);
        rd(att_cmd_pkg::OFF_STATUS);
        chk("nack", 16'h1, {15'h0, got[att_cmd_pkg::ST_NACK]});
        wr(att_cmd_pkg::OFF_STATUS, 16'h0004);
        rd(att_cmd_pkg::OFF_STATUS);
        chk("nack clr", 16'h0, got);
        $display("test queue and nack done");
        // Own target address reaches slot 3
        wr(att_cmd_pkg::OFF_ADDR, 16'h0121);
        wr(att_cmd_pkg::OFF_CMD, 16'h0243);
        wrBase[3] = wrTotal[3];
        wr(att_cmd_pkg::OFF_SLOT_LAST, 16'h0);
        idle();
        chk("own bytes", 16'h2, 16'(wrTotal[3] - wrBase[3]));
        chk("own code", 16'h0043, {8'h0, lastCode[3]});
        rd(att_cmd_pkg::OFF_ADDR);
        chk("addr", 16'h0121, got);
        rd(8'h20);
        chk("unmapped", 16'h0, got);
        $display("test own address done");
        // Mid-run reset returns the registers to their reset values
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rd(att_cmd_pkg::OFF_ADDR);
        chk("addr after reset", 16'h0049, got);
        rd(att_cmd_pkg::OFF_CMD);
        chk("cmd after reset", 16'h0, got);
        $display("test mid-run reset done");
        end_of_test();
    end
endmodule // attenuator_i2c_command_port_test
